// [hdl/bts_ctrl.sv]
// How it works
// - software selects the pin as extra peripheral select or latched address bit two.
// - in select mode the pin asserts only for addresses inside the programmed window.
// - in latch mode the pin shows latched address bit two, held during bus hold.
// - direction is low for reads into the device, high for writes out.
// - transceiver enable is driven low during every memory and I/O access.
// - transceiver enable is high whenever the direction output changes level.
// - selects are active low and stay driven while another master holds the bus.
`timescale 1ns/1ps
`include "bts_map.svh"

module bts_ctrl
  import bts_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_reset,
  input  wire logic     i_hold,
  input  wire logic     i_req,
  input  wire bts_req_t i_req_info,
  input  wire logic     i_done,
  input  wire logic     i_cfg_we,
  input  wire bts_cfg_t i_cfg,
  output logic          o_busy,
  output logic          o_xcvr_direction,
  output logic          o_xcvr_output_enable_n,
  output logic          o_periph_sel_or_latched_addr_pin,
  output logic          o_latch_mode
);

  bts_regs_t r_q;
  bts_regs_t r_d;
  logic      take;
  logic      win_hit;

  // ----------------------------------------------------------------
  // address window decode
  // ----------------------------------------------------------------
  bts_range #(
    .W (`BTS_ADDR_W)
  ) u_range (
    .i_addr  (i_req_info.addr),
    .i_base  (r_q.cfg.base),
    .i_limit (r_q.cfg.limit),
    .o_hit   (win_hit)
  );

  // a request is only accepted while idle and owning the bus
  assign take = i_req && (r_q.st == BTS_IDLE) && !i_hold;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    if (i_cfg_we) begin
      r_d.cfg = i_cfg;
    end
    unique case (r_q.st)
      BTS_IDLE: begin
        if (take) begin
          // direction moves while the enable is still high
          r_d.dir = i_req_info.is_write ? `BTS_DIR_XMIT : `BTS_DIR_RECV;
          r_d.hit = win_hit;
          r_d.a2  = i_req_info.addr[`BTS_A2_BIT];
          r_d.st  = BTS_SETUP;
        end
      end
      BTS_SETUP: begin
        r_d.den_n = `BTS_ACTIVE;
        r_d.st    = BTS_XFER;
      end
      BTS_XFER: begin
        if (i_done) begin
          r_d.den_n = `BTS_INACTIVE;
          r_d.st    = BTS_IDLE;
        end
      end
    endcase
    // pin is always driven, even while the bus is held
    if (r_d.cfg.latch_mode) begin
      r_d.pin = r_d.a2;
    end else if ((r_d.st != BTS_IDLE) && r_d.hit) begin
      r_d.pin = `BTS_ACTIVE;
    end else begin
      r_d.pin = `BTS_INACTIVE;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r_q.st             <= BTS_IDLE;
      r_q.dir            <= `BTS_DIR_RECV;
      r_q.den_n          <= `BTS_INACTIVE;
      r_q.pin            <= `BTS_INACTIVE;
      r_q.a2             <= `BTS_RST_A2;
      r_q.hit            <= 1'b0;
      r_q.cfg.latch_mode <= `BTS_RST_LATCH_MODE;
      r_q.cfg.base       <= `BTS_RST_BASE;
      r_q.cfg.limit      <= `BTS_RST_LIMIT;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_busy                           = (r_q.st != BTS_IDLE);
  assign o_xcvr_direction                 = r_q.dir;
  assign o_xcvr_output_enable_n           = r_q.den_n;
  assign o_periph_sel_or_latched_addr_pin = r_q.pin;
  assign o_latch_mode                     = r_q.cfg.latch_mode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_setup;
    r_q.den_n && (r_q.st == BTS_SETUP);
  endsequence

  sequence s_xfer;
    !r_q.den_n && (r_q.st == BTS_XFER);
  endsequence

  property p_mode_cfg;
    i_cfg_we |=> (r_q.cfg.latch_mode == $past(i_cfg.latch_mode));
  endproperty
  a_mode_cfg: assert property (p_mode_cfg) else $error("mode bit not written");

  property p_mode_hold;
    !i_cfg_we |=> $stable(r_q.cfg.latch_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode bit changed alone");

  property p_sel_window;
    (take && !r_q.cfg.latch_mode && !i_cfg_we)
      |=> (o_periph_sel_or_latched_addr_pin == !$past(win_hit));
  endproperty
  a_sel_window: assert property (p_sel_window) else $error("select wrong for window");

  property p_a2_val;
    (take && r_q.cfg.latch_mode && !i_cfg_we)
      |=> (o_periph_sel_or_latched_addr_pin == $past(i_req_info.addr[`BTS_A2_BIT]));
  endproperty
  a_a2_val: assert property (p_a2_val) else $error("latched bit two wrong");

  property p_a2_hold;
    (r_q.cfg.latch_mode && i_hold && !i_cfg_we && (r_q.st == BTS_IDLE))
      |=> $stable(o_periph_sel_or_latched_addr_pin);
  endproperty
  a_a2_hold: assert property (p_a2_hold) else $error("latched bit moved in hold");

  property p_dir;
    take |=> (o_xcvr_direction == $past(i_req_info.is_write));
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");

  property p_den_access;
    take |=> s_setup ##1 s_xfer;
  endproperty
  a_den_access: assert property (p_den_access) else $error("enable not asserted");

  property p_den_dir;
    $changed(o_xcvr_direction) |-> (o_xcvr_output_enable_n && $past(o_xcvr_output_enable_n));
  endproperty
  a_den_dir: assert property (p_den_dir) else $error("direction moved while enabled");

  property p_sel_idle;
    (!r_q.cfg.latch_mode && (r_q.st == BTS_IDLE)) |-> o_periph_sel_or_latched_addr_pin;
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("select active while idle");

  // ----------------------------------------------------------------
  // access end, bus hold and reset
  // ----------------------------------------------------------------
  sequence s_release;
    r_q.den_n && (r_q.st == BTS_IDLE);
  endsequence

  property p_xfer_wait;
    ((r_q.st == BTS_XFER) && !i_done) |=> s_xfer;
  endproperty
  a_xfer_wait: assert property (p_xfer_wait) else $error("enable dropped early");

  property p_den_end;
    ((r_q.st == BTS_XFER) && i_done) |=> s_release;
  endproperty
  a_den_end: assert property (p_den_end) else $error("enable not released");

  property p_den_busy;
    !o_xcvr_output_enable_n |-> o_busy;
  endproperty
  a_den_busy: assert property (p_den_busy) else $error("enable low when idle");

  property p_dir_hold;
    !take |=> $stable(o_xcvr_direction);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved alone");

  property p_dir_setup;
    $changed(o_xcvr_direction) |-> (r_q.st == BTS_SETUP);
  endproperty
  a_dir_setup: assert property (p_dir_setup) else $error("direction moved late");

  property p_sel_miss;
    (!r_q.cfg.latch_mode && o_busy && !r_q.hit) |-> o_periph_sel_or_latched_addr_pin;
  endproperty
  a_sel_miss: assert property (p_sel_miss) else $error("select on a miss");

  property p_hold_sel;
    (i_hold && !i_cfg_we && !r_q.cfg.latch_mode && (r_q.st == BTS_IDLE))
      |=> ((r_q.st == BTS_IDLE) && o_periph_sel_or_latched_addr_pin);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("select moved in hold");

  property p_mode_reset;
    $fell(i_reset) |-> (!o_latch_mode && (r_q.cfg.limit == `BTS_RST_LIMIT));
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("pin function not reset");

endmodule

// [common/bts_map.svh]
`ifndef BTS_MAP_SVH
`define BTS_MAP_SVH

// ----------------------------------------------------------------
// widths and bit positions
// ----------------------------------------------------------------
`define BTS_ADDR_W          20
`define BTS_A2_BIT          2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BTS_RST_LATCH_MODE  1'b0
`define BTS_RST_BASE        20'h00000
`define BTS_RST_LIMIT       20'h0007f
`define BTS_RST_A2          1'b0

// ----------------------------------------------------------------
// pin levels
// ----------------------------------------------------------------
`define BTS_DIR_RECV        1'b0
`define BTS_DIR_XMIT        1'b1
`define BTS_INACTIVE        1'b1
`define BTS_ACTIVE          1'b0

`endif

// [common/bts_pkg.sv]
`include "bts_map.svh"

package bts_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BTS_IDLE   = 3'b001,
    BTS_SETUP  = 3'b010,
    BTS_XFER   = 3'b100
  } bts_state_t;

  typedef struct packed {
    logic [`BTS_ADDR_W-1:0] addr;
    logic                   is_write;
  } bts_req_t;

  typedef struct packed {
    logic                   latch_mode;
    logic [`BTS_ADDR_W-1:0] base;
    logic [`BTS_ADDR_W-1:0] limit;
  } bts_cfg_t;

  typedef struct packed {
    bts_state_t st;
    logic       dir;
    logic       den_n;
    logic       pin;
    logic       a2;
    logic       hit;
    bts_cfg_t   cfg;
  } bts_regs_t;

endpackage

// [hdl/bts_range.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// inclusive address window compare
// ----------------------------------------------------------------
module bts_range #(
  parameter int W = 20
) (
  input  wire logic [W-1:0] i_addr,
  input  wire logic [W-1:0] i_base,
  input  wire logic [W-1:0] i_limit,
  output logic              o_hit
);

  assign o_hit = (i_addr >= i_base) && (i_addr <= i_limit);

endmodule

// [test/bts_xcvr_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// transceiver: flags a direction flip while it is enabled
// ----------------------------------------------------------------
module bts_xcvr_model (
  input  wire logic i_clk,
  input  wire logic i_dir,
  input  wire logic i_oe_n,
  output logic      o_bad
);
  logic dir_q;
  logic bad_q = 1'b0;
  assign o_bad = bad_q;
  always @(posedge i_clk) begin
    if (i_dir !== dir_q && i_oe_n !== 1'b1 && dir_q !== 1'bx) bad_q <= 1'b1;
    dir_q <= i_dir;
  end
endmodule

// [test/bus_transceiver_select_control_tb.sv]
`timescale 1ns/1ps

module bus_transceiver_select_control_tb
  import bts_pkg::*;
;
  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
  logic     i_clk = 1'b0, i_reset = 1'b1, i_hold = 1'b0, i_req = 1'b0;
  logic     i_done = 1'b0, i_cfg_we = 1'b0;
  bts_req_t i_req_info = '0;
  bts_cfg_t i_cfg = '0;
  logic     busy, dir, oe_n, pin, lm, xbad;
  int       bad_count = 0, checks_done = 0;
  always #4 i_clk = ~i_clk;
  bts_ctrl uut (.i_clk(i_clk), .i_reset(i_reset), .i_hold(i_hold), .i_req(i_req),
    .i_req_info(i_req_info), .i_done(i_done), .i_cfg_we(i_cfg_we), .i_cfg(i_cfg),
    .o_busy(busy), .o_xcvr_direction(dir), .o_xcvr_output_enable_n(oe_n),
    .o_periph_sel_or_latched_addr_pin(pin), .o_latch_mode(lm));
  bts_xcvr_model xm (.i_clk(i_clk), .i_dir(dir), .i_oe_n(oe_n), .o_bad(xbad));
  task automatic test_done();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cfg(input logic m, input logic [19:0] b, input logic [19:0] l);
    @(posedge i_clk) begin
      i_cfg_we <= 1'b1;
      i_cfg <= '{latch_mode: m, base: b, limit: l};
    end
    @(posedge i_clk) i_cfg_we <= 1'b0;
    #1 `CHK(lm, m)
  endtask
  // one access; p is the pin while busy, pa after the end
  task automatic access(input logic [19:0] a, input logic w, input logic p,
                        input logic pa);
    @(posedge i_clk) begin
      i_req <= 1'b1;
      i_req_info <= '{addr: a, is_write: w};
    end
    @(posedge i_clk) i_req <= 1'b0;
    #1 `CHK({busy, dir, oe_n}, {1'b1, w, 1'b1})
    `CHK(pin, p)
    @(posedge i_clk) i_done <= 1'b1;
    #1 `CHK(oe_n, 1'b0)
    @(posedge i_clk) i_done <= 1'b0;
    #1 `CHK({busy, oe_n, pin}, {1'b0, 1'b1, pa})
    $display("access %h done", a);
  endtask
  task automatic t_reset();
    #1 `CHK({busy, dir, oe_n, pin, lm}, 5'h06)
    $display("reset done");
  endtask
  task automatic t_select();
    cfg(1'b0, 20'h00100, 20'h001ff);
    access(20'h00100, 1'b1, 1'b0, 1'b1);
    access(20'h001ff, 1'b0, 1'b0, 1'b1);
    access(20'h00200, 1'b0, 1'b1, 1'b1);
    access(20'h000ff, 1'b1, 1'b1, 1'b1);
    $display("select done");
  endtask
  task automatic t_latch();
    cfg(1'b1, 20'h00100, 20'h001ff);
    // last access of the select test had address bit two set
    `CHK(pin, 1'b1)
    access(20'h00004, 1'b0, 1'b1, 1'b1);
    @(posedge i_clk) i_hold <= 1'b1;
    @(posedge i_clk) begin
      i_req <= 1'b1;
      i_req_info <= '{addr: 20'h00000, is_write: 1'b1};
    end
    @(posedge i_clk) i_req <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 `CHK({busy, oe_n, pin}, 3'h3)
    @(posedge i_clk) i_hold <= 1'b0;
    access(20'h00003, 1'b1, 1'b0, 1'b0);
    cfg(1'b0, 20'h00000, 20'h0000f);
    `CHK(pin, 1'b1)
    access(20'h0000f, 1'b0, 1'b0, 1'b1);
    $display("latch done");
  endtask
  // mid-run reset brings back select mode and the reset window
  task automatic t_rerun();
    cfg(1'b1, 20'h00100, 20'h001ff);
    @(posedge i_clk) i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    access(20'h0007f, 1'b0, 1'b0, 1'b1);
    access(20'h00080, 1'b1, 1'b1, 1'b1);
    @(posedge i_clk) begin
      i_hold <= 1'b1;
      i_req <= 1'b1;
      i_req_info <= '{addr: 20'h00010, is_write: 1'b1};
    end
    @(posedge i_clk) begin
      i_hold <= 1'b0;
      i_req <= 1'b0;
    end
    #1 `CHK({busy, pin}, 2'h1)
    $display("rerun done");
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_select();
    t_latch();
    t_rerun();
    `CHK(xbad, 1'b0)
    test_done();
  end
  initial begin
    #20000;
    bad_count++;
    test_done();
  end
endmodule
